// ---- rtl/sar_adc_sequencer.sv ----
// sar_adc_sequencer: control logic for a 10-bit SAR converter, APB slave.
// assumes an analog comparator and sample switch outside; one clock.
// Functional notes
// - each conversion is a 10-bit successive-approximation search
// - single mode converts one channel; scan mode one to four
// - single conversion starts when start bit becomes 1 via source; here only software sets it, and a timer or pin source then triggers
// - finished conversion sets the conversion end flag; in scan mode the code sets it only when the last slot of a pass finishes
// - end flag with interrupt enable raises the end interrupt
// - scan keeps cycling until software writes start bit 0
// - scan raises end interrupt after first full pass
// - start source is software, timer trigger, or pin edge
// - four result registers, one per scan slot
// - per-channel conversion within 6.7 us at 20 MHz timing
// - channel select covers eight analog inputs
//
// Our own choices: the APB interface to the registers and the register offsets.
`default_nettype none
module sar_adc_sequencer (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// triggers
	input  wire logic        timer_trigger,
	input  wire logic        external_trigger_pin,
	// analog front end
	output logic             sample,
	output logic [9:0]       dac_code,
	output logic [2:0]       channel_sel,
	input  wire logic        cmp_hi,
	// interrupt
	output logic             conversion_end_interrupt
);
	sadc_if link ();
	sadc_sar u_sar (
		.clk      (clk),
		.reset    (reset),
		.sample   (sample),
		.dac_code (dac_code),
		.cmp_hi   (cmp_hi),
		.req      (link)
	);

	logic [31:0] ctrl;
	logic [1:0]  status;
	logic [1:0]  end_interrupt_enable;
	logic [9:0]  res [4];
	logic [2:0]  pin_sync;
	logic        pin_level;
	logic        busy;
	logic [1:0]  slot;
	logic        first_pass;
	logic        go_q;
	logic [2:0]  chan_q;

	wire conversion_start_bit = ctrl[sadc_pkg::CTRL_START];
	wire scan_mode = ctrl[sadc_pkg::CTRL_SCAN];
	wire [1:0] src = ctrl[sadc_pkg::CTRL_SRC_LO +: 2];
	wire [2:0] ch_base = ctrl[sadc_pkg::CTRL_CH_LO +: 3];
	wire [1:0] ch_last = ctrl[sadc_pkg::CTRL_CNT_LO +: 2];

	function automatic logic is_reg(input logic [7:0] a,
		input logic [7:0] off);
		return a == off;
	endfunction

	wire wr = psel && penable && pwrite;
	wire rd_ok = psel && !penable;
	// pin edge: second and third stages agree on a new high
	// a one-cycle glitch never reaches agreement, so it is filtered
	wire pin_rise = pin_sync[1] && pin_sync[2] && !pin_level;

	logic trig;
	always_comb begin
		unique case (src)
			2'(sadc_pkg::sadc_src_timer): trig = timer_trigger;
			2'(sadc_pkg::sadc_src_pin):   trig = pin_rise;
			default:                      trig = 1'b1;
		endcase
	end

	wire wr_ctrl = wr && is_reg(paddr, sadc_pkg::OFF_CTRL);
	wire pass_end = link.done && scan_mode && slot == ch_last;
	wire single_end = link.done && !scan_mode;

	always_ff @(posedge clk) begin
		if (reset)
			pin_sync <= 3'h0;
		else
			pin_sync <= {pin_sync[1:0], external_trigger_pin};
	end

	// filtered pin level: follows only once two stages agree
	always_ff @(posedge clk) begin
		if (reset)
			pin_level <= 1'b0;
		else if (pin_sync[1] == pin_sync[2])
			pin_level <= pin_sync[2];
	end

	// control register and auto-clear
	always_ff @(posedge clk) begin
		if (reset)
			ctrl <= sadc_pkg::CTRL_RESET;
		else if (wr_ctrl)
			ctrl <= pwdata & 32'h0000_037F;
		else if (single_end)
			ctrl[sadc_pkg::CTRL_START] <= 1'b0;
	end

	// sequencer: go issues a conversion when armed and triggered
	always_ff @(posedge clk) begin
		if (reset) begin
			busy <= 1'b0;
			slot <= 2'h0;
			go_q <= 1'b0;
			chan_q <= 3'h0;
			first_pass <= 1'b0;
		end else begin
			go_q <= 1'b0;
			if (!conversion_start_bit || wr_ctrl) begin
				busy <= 1'b0;
				slot <= 2'h0;
				first_pass <= 1'b0;
			end else if (!busy) begin
				if (trig) begin
					busy <= 1'b1;
					go_q <= 1'b1;
					slot <= 2'h0;
					chan_q <= ch_base;
				end
			end else if (link.done) begin
				if (scan_mode) begin
					slot <= (slot == ch_last) ? 2'h0 : slot + 2'h1;
					chan_q <= (slot == ch_last) ? ch_base :
						3'(ch_base + 3'(slot) + 3'h1);
					go_q <= 1'b1;
					if (slot == ch_last)
						first_pass <= 1'b1;
				end else
					busy <= 1'b0;
			end
		end
	end
	assign link.go = go_q;
	assign link.chan = chan_q;

	always_ff @(posedge clk) begin
		if (reset)
			channel_sel <= 3'h0;
		else
			channel_sel <= chan_q;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_res
			always_ff @(posedge clk) begin
				if (reset)
					res[gi] <= 10'h000;
				else if (link.done && slot == 2'(gi))
					res[gi] <= link.result;
			end
		end
	endgenerate

	// sticky end flags, write one to clear; set wins
	always_ff @(posedge clk) begin
		if (reset)
			status <= 2'h0;
		else begin
			for (int i = 0; i < 2; i++) begin
				if (wr && is_reg(paddr, sadc_pkg::OFF_STATUS) && pwdata[i])
					status[i] <= 1'b0;
			end
			if (single_end || pass_end)
				status[sadc_pkg::ST_END] <= 1'b1;
			if (pass_end && !first_pass)
				status[sadc_pkg::ST_PASS] <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			end_interrupt_enable <= 2'(sadc_pkg::MASK_RESET);
		else if (wr && is_reg(paddr, sadc_pkg::OFF_MASK))
			end_interrupt_enable <= pwdata[1:0];
	end

	always_ff @(posedge clk) begin
		if (reset)
			conversion_end_interrupt <= 1'b0;
		else
			conversion_end_interrupt <= |(status & end_interrupt_enable);
	end

	// apb: no wait states, read data registered in setup cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= rd_ok;
			pslverr <= 1'b0;
			if (rd_ok) begin
				prdata <= 32'h0000_0000;
				if (is_reg(paddr, sadc_pkg::OFF_CTRL))
					prdata <= ctrl;
				else if (is_reg(paddr, sadc_pkg::OFF_STATUS))
					prdata <= {30'h0, status};
				else if (is_reg(paddr, sadc_pkg::OFF_MASK))
					prdata <= {30'h0, end_interrupt_enable};
				else if (paddr[7:4] == 4'h1 && paddr[1:0] == 2'h0)
					prdata <= {22'h0, res[paddr[3:2]]};
				else
					pslverr <= 1'b1;
			end
		end
	end
endmodule // sar_adc_sequencer
`default_nettype wire

// ---- rtl/sadc_pkg.sv ----
// sadc_pkg: register map, field positions, reset values and timing
// for the converter sequencer; shared by the sequencer and its engine.
`default_nettype none
package sadc_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_MASK   = 8'h08;
	localparam logic [7:0] OFF_RES0   = 8'h10;
	// control field positions
	localparam int CTRL_START  = 0;
	localparam int CTRL_SCAN   = 1;
	localparam int CTRL_SRC_LO = 2;
	localparam int CTRL_CH_LO  = 4;
	localparam int CTRL_CNT_LO = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	// status bits
	localparam int ST_END  = 0;
	localparam int ST_PASS = 1;
	// start sources
	typedef enum logic [1:0] {
		sadc_src_soft,
		sadc_src_timer,
		sadc_src_pin
	} sadc_src_e;
	// timing: 6.7 us at 20 MHz is 134 cycles of a 50 ns clock
	localparam int REF_CYCLES_PER_CONV = 134;
	localparam int RESULT_BITS         = 10;
	localparam int SAMPLE_CYCLES       = REF_CYCLES_PER_CONV - 4 * 10 - 2;
	localparam int STEP_CYCLES         = 4;
endpackage
`default_nettype wire

// ---- rtl/sadc_if.sv ----
// sadc_if: carries conversion requests and results between the
// sequencer and its successive-approximation engine.
`default_nettype none
interface sadc_if;
	logic       go;
	logic [2:0] chan;
	logic       done;
	logic [9:0] result;
	modport seq (output go, output chan, input done, input result);
	modport eng (input go, input chan, output done, output result);
endinterface
`default_nettype wire

// ---- rtl/sadc_sar.sv ----
// sadc_sar: successive-approximation engine; one conversion per go.
// assumes an external comparator answers within one step period.
`default_nettype none
module sadc_sar (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// analog front end
	output logic       sample,
	output logic [9:0] dac_code,
	input  wire logic  cmp_hi,
	// sequencer side
	sadc_if.eng        req
);
	typedef enum {s_idle, s_samp, s_step} sadc_st_e;
	sadc_st_e  st;
	logic [7:0] cnt;
	logic [3:0] bit_i;
	always_ff @(posedge clk) begin
		if (reset) begin
			st <= s_idle;
			cnt <= 8'h00;
			bit_i <= 4'h0;
			sample <= 1'b0;
			dac_code <= 10'h000;
			req.done <= 1'b0;
			req.result <= 10'h000;
		end else begin
			req.done <= 1'b0;
			unique case (st)
				s_idle: begin
					if (req.go) begin
						st <= s_samp;
						sample <= 1'b1;
						cnt <= 8'(sadc_pkg::SAMPLE_CYCLES);
					end
				end
				s_samp: begin
					if (cnt == 8'h00) begin
						sample <= 1'b0;
						st <= s_step;
						bit_i <= 4'h9;
						dac_code <= 10'h200;
						cnt <= 8'(sadc_pkg::STEP_CYCLES - 1);
					end else
						cnt <= cnt - 8'h01;
				end
				s_step: begin
					if (cnt != 8'h00)
						cnt <= cnt - 8'h01;
					else begin
						if (!cmp_hi)
							dac_code[bit_i] <= 1'b0;
						if (bit_i == 4'h0) begin
							st <= s_idle;
							req.done <= 1'b1;
							req.result <= {dac_code[9:1],
								cmp_hi ? dac_code[0] : 1'b0};
						end else begin
							dac_code[bit_i - 4'h1] <= 1'b1;
							bit_i <= bit_i - 4'h1;
							cnt <= 8'(sadc_pkg::STEP_CYCLES - 1);
						end
					end
				end
			endcase
		end
	end
endmodule // sadc_sar
`default_nettype wire

// ---- testbench/sadc_chk.sv ----
// sadc_chk: port assertions for the converter sequencer
// assumes one clock and a synchronous active-high reset
`default_nettype none
module sadc_chk (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// converter
	input wire logic        sample,
	input wire logic [2:0]  channel_sel,
	input wire logic        conversion_end_interrupt
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic bad;
	assign bad = !(paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14,
		8'h18, 8'h1C});
	chk_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	chk_err_decode: assert property (pready |-> pslverr == bad)
		else $error("slave error wrong");
	chk_err_zero: assert property (pready && pslverr |->
		prdata == 32'h0000_0000)
		else $error("data on error");
	chk_sample_hold: assert property ($rose(sample) |=> sample [*8])
		else $error("sampling too short");
	chk_sample_end: assert property ($rose(sample) |-> ##[1:100] !sample)
		else $error("sampling too long");
	chk_step_gap: assert property ($fell(sample) |-> !sample [*8])
		else $error("steps cut short");
	chk_chan_hold: assert property (sample && $past(sample) |->
		$stable(channel_sel)) else $error("channel moved");
	chk_mask_off: assert property (pready && pwrite &&
		paddr == sadc_pkg::OFF_MASK && pwdata == 32'h0000_0000 |-> ##[1:2]
		!conversion_end_interrupt) else $error("irq not masked");
	cover property ($rose(conversion_end_interrupt));
	cover property (pready && pslverr);
	cover property ($fell(sample));
endmodule // sadc_chk
bind sar_adc_sequencer sadc_chk u_chk (.clk(clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sample(sample), .channel_sel(channel_sel),
	.conversion_end_interrupt(conversion_end_interrupt));
`default_nettype wire

// ---- testbench/sar_adc_sequencer_tb_top.sv ----
// sar_adc_sequencer_tb_top: apb master, trigger and comparator model
// assumes the package register map and a 200 MHz clock
`default_nettype none
module sar_adc_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr;
	logic        tmr, pin, sample, cmp_hi, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, seed, c;
	logic [9:0]  dac_code, ana [8];
	logic [2:0]  channel_sel, ch;
	logic [32:0] expq [$];
	int          n_fail, num_checks;
	sar_adc_sequencer dut (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_trigger(tmr),
		.external_trigger_pin(pin), .sample(sample),
		.dac_code(dac_code), .channel_sel(channel_sel),
		.cmp_hi(cmp_hi), .conversion_end_interrupt(irq));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// comparator answers a cycle late, well inside one step
	always @(posedge clk) cmp_hi <= ana[channel_sel] >= dac_code;
	always @(posedge clk) begin
		if (pready === 1'b1 && pwrite === 1'b0)
			chk({pslverr, prdata}, expq.pop_front());
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic fail(input string m);
		n_fail++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		num_checks++;
		if (g !== e)
			fail("read mismatch");
	endtask
	task automatic chkb(input logic g, input logic e);
		num_checks++;
		if (g !== e)
			fail("pin mismatch");
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 50 && pready !== 1'b1; i++) @(posedge clk);
		if (i == 50) begin
			fail("no ready");
			results();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic e);
		expq.push_back({e, d});
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic wait_irq(input int lim);
		int i;
		for (i = 0; i < lim && irq !== 1'b1; i++) @(posedge clk);
		if (i == lim) begin
			fail("irq timeout");
			results();
		end
	endtask
	task automatic quiet(input int n);
		logic hit;
		hit = 1'b0;
		repeat (n) begin
			@(posedge clk);
			hit |= sample;
		end
		chkb(hit, 1'b0);
	endtask
	initial begin
		seed = 32'hB;
		{psel, penable, pwrite, tmr, pin, cmp_hi} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		n_fail = 0;
		num_checks = 0;
		foreach (ana[k]) ana[k] = 10'(rnd());
		reset = 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(sadc_pkg::OFF_CTRL, sadc_pkg::CTRL_RESET, 1'b0);
		rd(sadc_pkg::OFF_MASK, sadc_pkg::MASK_RESET, 1'b0);
		rd(8'h0C, 32'h0, 1'b1);
		xfer(1'b1, sadc_pkg::OFF_MASK, 32'h1);
		// single mode through each start source
		for (int s = 0; s < 3; s++) begin
			ch = 3'(rnd());
			c = 32'({ch, 2'(s), 2'h1});
			xfer(1'b1, sadc_pkg::OFF_CTRL, c);
			if (s > 0) begin
				quiet(20);
				if (s == 1)
					tmr <= 1'b1;
				else
					pin <= 1'b1;
				@(posedge clk);
				tmr <= 1'b0;
			end
			wait_irq(400);
			// async pin is filtered: hold it until the end is seen
			pin <= 1'b0;
			rd(sadc_pkg::OFF_RES0, {22'h0, ana[ch]}, 1'b0);
			rd(sadc_pkg::OFF_CTRL, c & ~32'h1, 1'b0);
			rd(sadc_pkg::OFF_STATUS, 32'h1, 1'b0);
			xfer(1'b1, sadc_pkg::OFF_STATUS, 32'h3);
			rd(sadc_pkg::OFF_STATUS, 32'h0, 1'b0);
		end
		// four-channel scan, interrupt on first pass only
		ch = 3'(rnd()) & 3'h3;
		xfer(1'b1, sadc_pkg::OFF_MASK, 32'h2);
		xfer(1'b1, sadc_pkg::OFF_CTRL, 32'h303 | 32'({ch, 4'h0}));
		wait_irq(2000);
		for (int s = 0; s < 4; s++)
			rd(sadc_pkg::OFF_RES0 + 8'(4 * s), 32'(ana[ch + s]), 1'b0);
		rd(sadc_pkg::OFF_STATUS, 32'h3, 1'b0);
		xfer(1'b1, sadc_pkg::OFF_STATUS, 32'h3);
		repeat (700) @(posedge clk);
		chkb(irq, 1'b0);
		rd(sadc_pkg::OFF_STATUS, 32'h1, 1'b0);
		xfer(1'b1, sadc_pkg::OFF_MASK, 32'h0);
		xfer(1'b1, sadc_pkg::OFF_CTRL, 32'h0);
		repeat (150) @(posedge clk);
		quiet(400);
		results();
	end
endmodule // sar_adc_sequencer_tb_top
`default_nettype wire
